// ---- hw/rpm_pkg.sv ----
// types shared by the rx port mode block
`default_nettype none
package rpm_pkg;
   typedef enum logic [1:0] {
      RPM_MODE_CSI2 = 2'h0,
      RPM_MODE_RAW12_LF = 2'h1,
      RPM_MODE_RAW12_HF = 2'h2,
      RPM_MODE_RAW10 = 2'h3
   } rpm_mode_t;
   typedef enum logic [2:0] {
      RPM_BC_50M = 3'h0,
      RPM_BC_10M = 3'h2,
      RPM_BC_2M5 = 3'h4
   } rpm_bc_t;
   typedef struct packed {
      logic valid;
      logic write;
      logic remote;
      logic [6:0] target;
      logic [7:0] addr;
      logic [7:0] wdata;
   } rpm_req_t;
   typedef struct packed {
      rpm_mode_t mode;
      logic csi2_sync;
      logic [5:0] frame_bits;
      rpm_bc_t bc_rate;
   } rpm_port_cfg_t;
endpackage
`default_nettype wire

// ---- hw/rpm_ref_monitor.sv ----
// reference clock activity watchdog and clock source select
`default_nettype none
`include "rpm_regs.svh"
module rpm_ref_monitor #(
   parameter int GAP_CYC = `RPM_REF_GAP_CYC
) (
   input wire logic core_clk_in,
   input wire logic sys_rst_in,
   input wire logic ref_level_in,
   output logic ref_lost_out,
   output logic use_backup_osc_out
);
   // -----------------------------------------------------------------
   // edge watch
   // -----------------------------------------------------------------
   initial begin
      if (GAP_CYC < 1) $error("rpm_ref_monitor: GAP_CYC must be >= 1");
   end
   logic ref_q;
   logic seen_edge;
   logic [$clog2(GAP_CYC+2)-1:0] gap_cnt;
   always_ff @(posedge core_clk_in) begin
      if (sys_rst_in) begin
         ref_q <= 1'b0;
      end else begin
         ref_q <= ref_level_in;
      end
   end
   // count beyond the limit so a gap of exactly the limit is tolerated
   always_ff @(posedge core_clk_in) begin
      if (sys_rst_in) begin
         gap_cnt <= '0;
         ref_lost_out <= 1'b0;
      end else if (ref_q != ref_level_in) begin
         gap_cnt <= '0;
         ref_lost_out <= 1'b0;
      end else if (gap_cnt > ($clog2(GAP_CYC+2))'(GAP_CYC)) begin
         ref_lost_out <= seen_edge;
      end else begin
         gap_cnt <= gap_cnt + 1'b1;
      end
   end
   // backup oscillator until the reference has toggled at all
   always_ff @(posedge core_clk_in) begin
      if (sys_rst_in) begin
         seen_edge <= 1'b0;
         use_backup_osc_out <= 1'b1;
      end else if (ref_q != ref_level_in) begin
         seen_edge <= 1'b1;
         use_backup_osc_out <= 1'b0;
      end
   end
endmodule
`default_nettype wire

// ---- hw/rpm_regs.svh ----
// register offsets, fields, reset values and timing counts for rpm block
`ifndef RPM_REGS_SVH
`define RPM_REGS_SVH
`define RPM_ADDR_PORT_DISABLE 8'h0C
`define RPM_ADDR_FWD_CTRL 8'h20
`define RPM_ADDR_PAGE_SEL 8'h4C
`define RPM_ADDR_BC_RATE 8'h58
`define RPM_ADDR_PORT_CFG 8'h6D
`define RPM_ADDR_DIRECT_BASE 8'hF8
`define RPM_ADDR_DIRECT_LAST 8'hFB
`define RPM_RST_PORT_DISABLE 8'h00
`define RPM_RST_FWD_CTRL 8'h00
`define RPM_RST_BC_RATE 8'h00
`define RPM_RST_DIRECT_ADDR 8'h00
`define RPM_BC_RATE_LSB 0
`define RPM_BC_RATE_MSB 2
`define RPM_BC_RATE_10M 3'h2
`define RPM_MODE_LSB 0
`define RPM_MODE_MSB 1
`define RPM_DIRECT_EN_BIT 7
`define RPM_FWD_EN_LSB 0
`define RPM_PAGE_WR_LSB 0
`define RPM_PAGE_RD_LSB 4
`define RPM_FRAME_CSI2 6'h28
`define RPM_FRAME_RAW 6'h1C
`define RPM_REF_GAP_NS 20000
`define RPM_CLK_PERIOD_NS 40
`define RPM_REF_GAP_CYC ((`RPM_REF_GAP_NS) / (`RPM_CLK_PERIOD_NS))
`endif

// ---- hw/rpm_top.sv ----
// rx port mode, paging and access control register bank
`default_nettype none
`include "rpm_regs.svh"
// Summary of operation
// - strap index 0/4 csi2, 1/5 lf, 2/6 hf, 3/7 raw10
// - csi2 ports use 40-bit frames
// - csi2 back channel defaults to 50 Mbps
// - raw ports use 28-bit frames
// - raw back channel defaults to 2.5 Mbps
// - strap mode loaded into readable writable field
// - reference gap over 20 us flags loss after the first reference edge
// - start up on backup oscillator
// - port disable bits per receive port
// - disable bits writable only by local controller
// - page select chooses visible port page
// - page select resets to all port pages for writes, port 0 for reads
// - four direct addresses reach port pages
// - direct addresses also reach shared registers
// - forwarding disabled at reset, enabled per port
// - each port holds its own receive mode
module rpm_top #(
   parameter int NUM_PORTS = 4,
   parameter int REF_GAP_CYC = `RPM_REF_GAP_CYC,
   parameter logic [6:0] MAIN_I2C_ADDR = 7'h3D
) (
   input wire logic core_clk_in,
   input wire logic sys_rst_in,
   input wire logic [2:0] mode_strap_in,
   input wire logic ref_level_in,
   input wire rpm_pkg::rpm_req_t req_in,
   output logic [7:0] rdata_out,
   output logic ack_out,
   output logic nack_out,
   output logic [NUM_PORTS-1:0] port_enable_out,
   output logic [NUM_PORTS-1:0] fwd_enable_out,
   output rpm_pkg::rpm_port_cfg_t [NUM_PORTS-1:0] port_cfg_out,
   output logic ref_lost_out,
   output logic use_backup_osc_out
);
   initial begin
      if (NUM_PORTS != 4) $error("rpm_top: NUM_PORTS must be 4");
      if (REF_GAP_CYC < 1) $error("rpm_top: REF_GAP_CYC must be >= 1");
   end

   // -----------------------------------------------------------------
   // storage
   // -----------------------------------------------------------------
   logic [7:0] port_disable;
   logic [7:0] fwd_ctrl;
   logic [7:0] page_sel;
   rpm_pkg::rpm_mode_t mode_q [NUM_PORTS];
   logic [2:0] bc_rate_q [NUM_PORTS];
   logic [7:0] direct_q [NUM_PORTS];
   logic strap_loaded;
   logic ref_lost_w;
   logic backup_w;

   // -----------------------------------------------------------------
   // strap decode
   // -----------------------------------------------------------------
   rpm_pkg::rpm_mode_t strap_mode;
   logic strap_sync;
   always_comb begin
      strap_sync = mode_strap_in == 3'h4;
      case (mode_strap_in[1:0])
         2'h0: strap_mode = rpm_pkg::RPM_MODE_CSI2;
         2'h1: strap_mode = rpm_pkg::RPM_MODE_RAW12_LF;
         2'h2: strap_mode = rpm_pkg::RPM_MODE_RAW12_HF;
         2'h3: strap_mode = rpm_pkg::RPM_MODE_RAW10;
         default: strap_mode = rpm_pkg::RPM_MODE_CSI2;
      endcase
   end
   logic strap_sync_q;

   // -----------------------------------------------------------------
   // target decode
   // -----------------------------------------------------------------
   logic hit_main;
   logic hit_direct;
   logic [1:0] direct_port;
   logic is_port_reg;
   logic shared_hit;
   logic [NUM_PORTS-1:0] wr_ports;
   logic [1:0] rd_port;
   always_comb begin
      hit_direct = 1'b0;
      direct_port = 2'h0;
      for (int i = 0; i < NUM_PORTS; i++) begin
         if (direct_q[i][`RPM_DIRECT_EN_BIT] &&
             direct_q[i][6:0] == req_in.target && !hit_direct) begin
            hit_direct = 1'b1;
            direct_port = 2'(i);
         end
      end
      hit_main = req_in.target == MAIN_I2C_ADDR;
      is_port_reg = req_in.addr == `RPM_ADDR_BC_RATE ||
                    req_in.addr == `RPM_ADDR_PORT_CFG;
      shared_hit = req_in.addr == `RPM_ADDR_PORT_DISABLE ||
                   req_in.addr == `RPM_ADDR_FWD_CTRL ||
                   req_in.addr == `RPM_ADDR_PAGE_SEL ||
                   (req_in.addr >= `RPM_ADDR_DIRECT_BASE &&
                    req_in.addr <= `RPM_ADDR_DIRECT_LAST);
      if (hit_direct) begin
         wr_ports = 4'(1) << direct_port;
         rd_port = direct_port;
      end else begin
         wr_ports = page_sel[3:0];
         rd_port = 2'h0;
         for (int i = NUM_PORTS - 1; i >= 0; i--) begin
            if (page_sel[`RPM_PAGE_RD_LSB + i]) rd_port = 2'(i);
         end
      end
   end
   logic sel_ok;
   logic wr_go;
   assign sel_ok = req_in.valid && (hit_main || hit_direct) &&
                   (is_port_reg || shared_hit);
   assign wr_go = sel_ok && req_in.write;

   // -----------------------------------------------------------------
   // shared registers
   // -----------------------------------------------------------------
   always_ff @(posedge core_clk_in) begin
      if (sys_rst_in) begin
         port_disable <= `RPM_RST_PORT_DISABLE;
      end else if (wr_go && !req_in.remote &&
                   req_in.addr == `RPM_ADDR_PORT_DISABLE) begin
         port_disable <= req_in.wdata;
      end
   end
   always_ff @(posedge core_clk_in) begin
      if (sys_rst_in) begin
         fwd_ctrl <= `RPM_RST_FWD_CTRL;
      end else if (wr_go && req_in.addr == `RPM_ADDR_FWD_CTRL) begin
         fwd_ctrl <= req_in.wdata;
      end
   end
   // reset selects every port for writes and port 0 for reads
   always_ff @(posedge core_clk_in) begin
      if (sys_rst_in) begin
         page_sel <= 8'h0F;
      end else if (wr_go && req_in.addr == `RPM_ADDR_PAGE_SEL) begin
         page_sel <= req_in.wdata;
      end
   end

   // -----------------------------------------------------------------
   // per-port registers
   // -----------------------------------------------------------------
   always_ff @(posedge core_clk_in) begin
      if (sys_rst_in) begin
         strap_loaded <= 1'b0;
         strap_sync_q <= 1'b0;
      end else if (!strap_loaded) begin
         strap_loaded <= 1'b1;
         strap_sync_q <= strap_sync;
      end
   end
   genvar p;
   generate
      for (p = 0; p < NUM_PORTS; p++) begin : g_port
         // strap is caught on the first clock after reset release
         always_ff @(posedge core_clk_in) begin
            if (sys_rst_in) begin
               mode_q[p] <= rpm_pkg::RPM_MODE_CSI2;
            end else if (!strap_loaded) begin
               mode_q[p] <= strap_mode;
            end else if (wr_go && wr_ports[p] &&
                         req_in.addr == `RPM_ADDR_PORT_CFG) begin
               mode_q[p] <= rpm_pkg::rpm_mode_t'(
                  req_in.wdata[`RPM_MODE_MSB:`RPM_MODE_LSB]);
            end
         end
         // rate defaults follow the strapped mode; software may retune
         always_ff @(posedge core_clk_in) begin
            if (sys_rst_in) begin
               bc_rate_q[p] <= 3'(`RPM_RST_BC_RATE);
            end else if (!strap_loaded) begin
               bc_rate_q[p] <= (strap_mode == rpm_pkg::RPM_MODE_CSI2) ?
                  rpm_pkg::RPM_BC_50M : rpm_pkg::RPM_BC_2M5;
            end else if (wr_go && wr_ports[p] &&
                         req_in.addr == `RPM_ADDR_BC_RATE) begin
               bc_rate_q[p] <=
                  req_in.wdata[`RPM_BC_RATE_MSB:`RPM_BC_RATE_LSB];
            end
         end
         always_ff @(posedge core_clk_in) begin
            if (sys_rst_in) begin
               direct_q[p] <= `RPM_RST_DIRECT_ADDR;
            end else if (wr_go &&
                         req_in.addr == `RPM_ADDR_DIRECT_BASE + 8'(p)) begin
               direct_q[p] <= req_in.wdata;
            end
         end
         always_ff @(posedge core_clk_in) begin
            if (sys_rst_in) begin
               port_cfg_out[p] <= '0;
               port_enable_out[p] <= 1'b0;
               fwd_enable_out[p] <= 1'b0;
            end else begin
               port_cfg_out[p].mode <= mode_q[p];
               port_cfg_out[p].csi2_sync <= strap_sync_q &&
                  mode_q[p] == rpm_pkg::RPM_MODE_CSI2;
               port_cfg_out[p].frame_bits <=
                  (mode_q[p] == rpm_pkg::RPM_MODE_CSI2) ?
                  `RPM_FRAME_CSI2 : `RPM_FRAME_RAW;
               port_cfg_out[p].bc_rate <= rpm_pkg::rpm_bc_t'(bc_rate_q[p]);
               port_enable_out[p] <= !port_disable[p];
               fwd_enable_out[p] <= fwd_ctrl[`RPM_FWD_EN_LSB + p];
            end
         end
      end
   endgenerate

   // -----------------------------------------------------------------
   // read path and answer
   // -----------------------------------------------------------------
   logic [7:0] next_rdata;
   always_comb begin
      next_rdata = 8'h00;
      case (req_in.addr)
         `RPM_ADDR_PORT_DISABLE: next_rdata = port_disable;
         `RPM_ADDR_FWD_CTRL: next_rdata = fwd_ctrl;
         `RPM_ADDR_PAGE_SEL: next_rdata = page_sel;
         `RPM_ADDR_BC_RATE: next_rdata = {5'h00, bc_rate_q[rd_port]};
         `RPM_ADDR_PORT_CFG: next_rdata = {6'h00, mode_q[rd_port]};
         default: begin
            for (int i = 0; i < NUM_PORTS; i++) begin
               if (req_in.addr == `RPM_ADDR_DIRECT_BASE + 8'(i))
                  next_rdata = direct_q[i];
            end
         end
      endcase
   end
   // a remote write to the disable register is nacked, not stored
   always_ff @(posedge core_clk_in) begin
      if (sys_rst_in) begin
         rdata_out <= 8'h00;
         ack_out <= 1'b0;
         nack_out <= 1'b0;
      end else begin
         rdata_out <= (sel_ok && !req_in.write) ? next_rdata : 8'h00;
         ack_out <= sel_ok && !(req_in.write && req_in.remote &&
                    req_in.addr == `RPM_ADDR_PORT_DISABLE);
         nack_out <= req_in.valid && !(sel_ok && !(req_in.write &&
                     req_in.remote &&
                     req_in.addr == `RPM_ADDR_PORT_DISABLE));
      end
   end

   // -----------------------------------------------------------------
   // reference clock supervision
   // -----------------------------------------------------------------
   rpm_ref_monitor #(
      .GAP_CYC(REF_GAP_CYC)
   ) u_ref_mon (
      .core_clk_in(core_clk_in),
      .sys_rst_in(sys_rst_in),
      .ref_level_in(ref_level_in),
      .ref_lost_out(ref_lost_w),
      .use_backup_osc_out(backup_w)
   );
   always_ff @(posedge core_clk_in) begin
      if (sys_rst_in) begin
         ref_lost_out <= 1'b0;
         use_backup_osc_out <= 1'b1;
      end else begin
         ref_lost_out <= ref_lost_w;
         use_backup_osc_out <= backup_w;
      end
   end
endmodule
`default_nettype wire

// ---- test/rpm_ctrl_model.sv ----
// local register controller model driving the request port
`default_nettype none
module rpm_ctrl_model (
   input wire logic core_clk_in,
   input wire logic ack_in,
   input wire logic nack_in,
   input wire logic [7:0] rdata_in,
   output var rpm_pkg::rpm_req_t req_out
);
   timeunit 1ns;
   timeprecision 1ps;
   initial req_out = '0;
   task automatic access(input logic wr, input logic rem,
         input logic [6:0] tgt, input logic [7:0] a, input logic [7:0] d,
         output logic ok, output logic bad, output logic [7:0] rd);
      @(negedge core_clk_in);
      req_out <= '{valid: 1'b1, write: wr, remote: rem, target: tgt,
         addr: a, wdata: d};
      @(negedge core_clk_in);
      ok = ack_in;
      bad = nack_in;
      rd = rdata_in;
      // released fields flip so a stale request never looks current
      req_out <= '{valid: 1'b0, write: ~wr, remote: ~rem, target: ~tgt,
         addr: ~a, wdata: ~d};
   endtask
endmodule
`default_nettype wire

// ---- test/rpm_top_props.sv ----
// concurrent checks on the ports of the rx port mode register bank
`default_nettype none
module rpm_top_props #(
   parameter int NUM_PORTS = 4,
   parameter int REF_GAP_CYC = 8
) (
   input wire logic core_clk_in,
   input wire logic sys_rst_in,
   input wire logic [2:0] mode_strap_in,
   input wire logic ref_level_in,
   input wire rpm_pkg::rpm_req_t req_in,
   input wire logic [7:0] rdata_out,
   input wire logic ack_out,
   input wire logic nack_out,
   input wire logic [NUM_PORTS-1:0] port_enable_out,
   input wire logic [NUM_PORTS-1:0] fwd_enable_out,
   input wire rpm_pkg::rpm_port_cfg_t [NUM_PORTS-1:0] port_cfg_out,
   input wire logic ref_lost_out,
   input wire logic use_backup_osc_out
);
   default clocking @(posedge core_clk_in); endclocking
   default disable iff (sys_rst_in);
   logic [1:0] up_cnt;
   logic ref_q;
   int quiet_cnt;
   // ----------------------------------------
   // helper counters
   // ----------------------------------------
   always_ff @(posedge core_clk_in) begin
      if (sys_rst_in)
         up_cnt <= 2'h0;
      else if (up_cnt != 2'h3)
         up_cnt <= up_cnt + 2'h1;
   end
   // edges seen since the reference pin last moved
   always_ff @(posedge core_clk_in) begin
      if (sys_rst_in) begin
         ref_q <= 1'b0;
         quiet_cnt <= 0;
      end else begin
         ref_q <= ref_level_in;
         if (ref_level_in != ref_q)
            quiet_cnt <= 0;
         else
            quiet_cnt <= quiet_cnt + 1;
      end
   end
   // ----------------------------------------
   // assertions
   // ----------------------------------------
   answer_once_a: assert property (
      req_in.valid |=> ack_out ^ nack_out)
      else $error("request not answered once");
   idle_quiet_a: assert property (
      !req_in.valid |=> !ack_out && !nack_out && rdata_out == 8'h00)
      else $error("answer without request");
   remote_block_a: assert property (
      up_cnt == 2'h3 && req_in.valid && req_in.write && req_in.remote &&
      req_in.addr == 8'h0C |=> nack_out ##2 $stable(port_enable_out))
      else $error("tunnelled disable write not refused");
   port_en_cause_a: assert property (
      up_cnt == 2'h3 && $changed(port_enable_out) |->
      $past(ack_out) && $past(req_in.addr, 2) == 8'h0C)
      else $error("port enables moved without a write");
   fwd_cause_a: assert property (
      $changed(fwd_enable_out) |-> $past(ack_out) &&
      $past(req_in.write, 2) && $past(req_in.addr, 2) == 8'h20)
      else $error("forwarding moved without a write");
   fwd_reset_a: assert property (
      $past(sys_rst_in) |-> fwd_enable_out == '0)
      else $error("forwarding on after reset");
   backup_start_a: assert property (
      $past(sys_rst_in) |-> use_backup_osc_out && !ref_lost_out)
      else $error("backup oscillator not used at start");
   ref_loss_a: assert property (
      quiet_cnt > REF_GAP_CYC + 5 && !use_backup_osc_out |-> ref_lost_out)
      else $error("reference gap not flagged");
   ref_alive_a: assert property (
      quiet_cnt > 4 && quiet_cnt < REF_GAP_CYC - 1 |-> !ref_lost_out)
      else $error("reference loss flagged early");
   for (genvar i = 0; i < NUM_PORTS; i++) begin : g_port
      strap_mode_a: assert property (
         up_cnt == 2'h2 |-> port_cfg_out[i].mode == mode_strap_in[1:0] &&
         port_cfg_out[i].csi2_sync == (mode_strap_in == 3'h4) &&
         port_cfg_out[i].bc_rate == (mode_strap_in[1:0] == 2'h0 ?
         rpm_pkg::RPM_BC_50M : rpm_pkg::RPM_BC_2M5))
         else $error("strap mode not loaded");
      frame_len_a: assert property (
         up_cnt == 2'h3 |-> port_cfg_out[i].frame_bits ==
         (port_cfg_out[i].mode == rpm_pkg::RPM_MODE_CSI2 ? 6'h28 : 6'h1C))
         else $error("frame length does not follow mode");
   end
endmodule
bind rpm_top rpm_top_props #(
   .NUM_PORTS(NUM_PORTS),
   .REF_GAP_CYC(REF_GAP_CYC)
) rpm_top_props_i (
   .core_clk_in, .sys_rst_in, .mode_strap_in, .ref_level_in, .req_in,
   .rdata_out, .ack_out, .nack_out, .port_enable_out, .fwd_enable_out,
   .port_cfg_out, .ref_lost_out, .use_backup_osc_out
);
`default_nettype wire

// ---- test/tb_rpm_top.sv ----
// self-checking bench for the rx port mode register bank
`default_nettype none
module tb_rpm_top;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int GAP = 8;
   localparam logic [6:0] MAIN = 7'h3D;
   localparam logic [6:0] DIRECT = 7'h21;
   logic core_clk_in = 1'b0;
   logic sys_rst_in = 1'b1;
   logic [2:0] mode_strap_in = 3'h0;
   logic ref_level_in = 1'b0;
   rpm_pkg::rpm_req_t req;
   rpm_pkg::rpm_port_cfg_t [3:0] cfg;
   logic [7:0] rdata;
   logic ack, nack, ref_lost, backup;
   logic [3:0] port_en, fwd_en;
   int mismatches = 0;
   int checks_done = 0;
   always #20 core_clk_in = ~core_clk_in;
   rpm_top #(.NUM_PORTS(4), .REF_GAP_CYC(GAP),
      .MAIN_I2C_ADDR(MAIN)) rpm_top_i (
      .core_clk_in, .sys_rst_in, .mode_strap_in, .ref_level_in,
      .req_in(req), .rdata_out(rdata), .ack_out(ack), .nack_out(nack),
      .port_enable_out(port_en), .fwd_enable_out(fwd_en),
      .port_cfg_out(cfg), .ref_lost_out(ref_lost),
      .use_backup_osc_out(backup));
   rpm_ctrl_model rpm_ctrl_model_i (.core_clk_in, .ack_in(ack),
      .nack_in(nack), .rdata_in(rdata), .req_out(req));
   // ----------------------------------------
   // tasks
   // ----------------------------------------
   task automatic give_verdict();
      if (mismatches == 0 && checks_done > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   task automatic chk(input string name, input logic [7:0] seen,
         input logic [7:0] exp);
      checks_done++;
      if (seen !== exp) begin
         mismatches++;
         $display("Error %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic do_reset(input logic [2:0] strap);
      @(negedge core_clk_in);
      sys_rst_in = 1'b1;
      mode_strap_in = strap;
      repeat (4) @(negedge core_clk_in);
      sys_rst_in = 1'b0;
      repeat (3) @(negedge core_clk_in);
   endtask
   task automatic xfer(input logic w, input logic rem, input logic [6:0] t,
         input logic [7:0] a, input logic [7:0] d, input logic ok_exp,
         input logic [7:0] rd_exp);
      logic ok, bad;
      logic [7:0] rd;
      rpm_ctrl_model_i.access(w, rem, t, a, d, ok, bad, rd);
      chk("ack", {7'h00, ok}, {7'h00, ok_exp});
      chk("nack", {7'h00, bad}, {7'h00, !ok_exp});
      if (!w && ok_exp)
         chk("read data", rd, rd_exp);
   endtask
   // ----------------------------------------
   // tests
   // ----------------------------------------
   initial begin
      for (int s = 0; s < 8; s++) begin
         do_reset(3'(s));
         xfer(0, 0, MAIN, 8'h6D, 8'h00, 1, {6'h00, 2'(s)});
         xfer(0, 0, MAIN, 8'h58, 8'h00, 1,
            (s % 4) ? 8'h04 : 8'h00);
         chk("frame", {2'h0, cfg[3].frame_bits},
            (s % 4) ? 8'h1C : 8'h28);
      end
      chk("fwd reset", {4'h0, fwd_en}, 8'h00);
      chk("backup", {7'h00, backup}, 8'h01);
      xfer(0, 0, MAIN, 8'h4C, 8'h00, 1, 8'h0F);
      xfer(0, 0, MAIN, 8'h0C, 8'h00, 1, 8'h00);
      xfer(1, 0, MAIN, 8'h58, 8'h02, 1, 8'h00);
      xfer(1, 0, MAIN, 8'h4C, 8'h02, 1, 8'h00);
      xfer(1, 0, MAIN, 8'h6D, 8'h00, 1, 8'h00);
      @(negedge core_clk_in);
      chk("rate", {5'h00, cfg[1].bc_rate}, 8'h02);
      chk("port1 mode", {6'h00, cfg[1].mode}, 8'h00);
      chk("port1 frame", {2'h0, cfg[1].frame_bits}, 8'h28);
      chk("port0 mode", {6'h00, cfg[0].mode}, 8'h03);
      xfer(0, 0, MAIN, 8'h6D, 8'h00, 1, 8'h03);
      xfer(1, 0, MAIN, 8'h4C, 8'h20, 1, 8'h00);
      xfer(0, 0, MAIN, 8'h6D, 8'h00, 1, 8'h00);
      xfer(1, 0, MAIN, 8'hFA, {1'b1, DIRECT}, 1, 8'h00);
      xfer(1, 0, DIRECT, 8'h6D, 8'h01, 1, 8'h00);
      xfer(0, 0, DIRECT, 8'h6D, 8'h00, 1, 8'h01);
      xfer(1, 0, DIRECT, 8'h20, 8'h05, 1, 8'h00);
      @(negedge core_clk_in);
      chk("port2 mode", {6'h00, cfg[2].mode}, 8'h01);
      chk("fwd", {4'h0, fwd_en}, 8'h05);
      xfer(0, 0, 7'h22, 8'h20, 8'h00, 0, 8'h00);
      xfer(0, 0, MAIN, 8'h01, 8'h00, 0, 8'h00);
      xfer(1, 1, MAIN, 8'h0C, 8'h0F, 0, 8'h00);
      @(negedge core_clk_in);
      chk("tunnelled", {4'h0, port_en}, 8'h0F);
      xfer(1, 0, MAIN, 8'h0C, 8'h05, 1, 8'h00);
      @(negedge core_clk_in);
      chk("disable", {4'h0, port_en}, 8'h0A);
      repeat (12) begin
         @(negedge core_clk_in);
         ref_level_in = ~ref_level_in;
      end
      repeat (2) @(negedge core_clk_in);
      chk("backup off", {7'h00, backup}, 8'h00);
      chk("ref alive", {7'h00, ref_lost}, 8'h00);
      repeat (GAP + 8) @(negedge core_clk_in);
      chk("ref lost", {7'h00, ref_lost}, 8'h01);
      give_verdict();
   end
   // run is under two hundred cycles; this limit only catches a hang
   initial begin
      repeat (5000) @(posedge core_clk_in);
      mismatches++;
      give_verdict();
   end
endmodule
`default_nettype wire
